/* hw/psc_pkg.sv */
// psc_pkg: constants and types for the power controller status and control registers
// assumes a serial management front end that presents subaddress, strobes and data bytes
// ----------------------------------------------------------------
// Contract
// - status register sits at subaddress 05h; seal and nvm bits mirror seal_broken_in and nvm_changed_in, reset does not clear them
// - status bit 7 reads 1 once factory seal broken, else 0; read-only
// - status bit 6 reads 1 when nvm defaults differ from factory
// - status bit 5 reads 1 while adapter-detect pin is low
// - status bit 4 reads 1 while push-button pin is low
// - status bits 3-2 give power state: transitional, wait rail, active, suspend
// - status bits 1-0 give coin-cell level: below low, low, good, ideal
// - control register at subaddress 06h, resets 00h, bits 7-2 reserved read-only
// - writing 1 to control bit 0 starts measurement, then bit self-clears
// - control bit 1 set and power-fail low shuts all rails, enters off
// - control bit 1 clear: power-fail low leaves power state untouched
// ----------------------------------------------------------------
package psc_pkg;
  localparam logic [7:0] PSC_ADDR_STATUS = 8'h05;
  localparam logic [7:0] PSC_ADDR_CONTROL = 8'h06;
  localparam logic [7:0] PSC_CONTROL_RESET = 8'h00;
  localparam int PSC_BIT_SEAL = 7;
  localparam int PSC_BIT_NVM = 6;
  localparam int PSC_BIT_ADAPTER = 5;
  localparam int PSC_BIT_BUTTON = 4;
  localparam int PSC_BIT_SHUTDOWN_EN = 1;
  localparam int PSC_BIT_MEASURE_GO = 0;
  localparam logic [1:0] PSC_CELL_BELOW_LOW = 2'h0;
  localparam logic [1:0] PSC_CELL_IDEAL = 2'h3;

  typedef enum logic [1:0] {
    PSC_ST_TRANSITIONAL = 2'b00,
    PSC_ST_WAIT_RAIL = 2'b01,
    PSC_ST_ACTIVE = 2'b10,
    PSC_ST_SUSPEND = 2'b11
  } psc_state_t;
endpackage : psc_pkg

/* hw/psc_regs.sv */
// psc_regs: status and control registers of the power controller
// assumes host access strobes are single-cycle and synchronous to sys_clk
`timescale 1ns/100ps
module psc_regs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic adapter_detect_pin,
  input wire logic pushbutton_pin,
  input wire logic powerfail_out_n,
  input wire logic seal_broken_in,
  input wire logic nvm_changed_in,
  input wire psc_pkg::psc_state_t power_state_in,
  input wire logic [1:0] cell_level_in,
  input wire logic cell_level_valid,
  output logic backup_cell_measure_start,
  output logic powerfail_shutdown_req,
  output logic powerfail_shutdown_en
);
  import psc_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic shutdown_en_reg;
  logic shutdown_en_next;
  logic measure_go_reg;
  logic measure_go_next;
  logic shutdown_req_reg;
  logic shutdown_req_next;
  logic [1:0] cell_level_reg;
  logic [1:0] cell_level_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] status_now;

  function automatic logic [7:0] psc_status(input logic seal, input logic nvm,
                                            input logic ac_pin, input logic btn_pin,
                                            input psc_state_t st, input logic [1:0] lvl);
    logic [7:0] s;
    s = 8'h00;
    s[PSC_BIT_SEAL] = seal;
    s[PSC_BIT_NVM] = nvm;
    s[PSC_BIT_ADAPTER] = ~ac_pin;
    s[PSC_BIT_BUTTON] = ~btn_pin;
    s[3:2] = st;
    s[1:0] = lvl;
    return s;
  endfunction : psc_status

  always_comb begin
    shutdown_en_next = shutdown_en_reg;
    measure_go_next = 1'b0;
    cell_level_next = cell_level_reg;
    // the bit pulses one cycle, so a second write of 1 restarts cleanly
    // only bits 1-0 are stored, so status and reserved writes fall away
    if (reg_wr && reg_addr == PSC_ADDR_CONTROL) begin
      shutdown_en_next = reg_wdata[PSC_BIT_SHUTDOWN_EN];
      measure_go_next = reg_wdata[PSC_BIT_MEASURE_GO];
    end
    // level is held from the last completed measurement only
    if (cell_level_valid) begin
      cell_level_next = cell_level_in;
    end
    shutdown_req_next = shutdown_en_reg && !powerfail_out_n;
    status_now = psc_status(seal_broken_in, nvm_changed_in, adapter_detect_pin,
                            pushbutton_pin, power_state_in, cell_level_reg);
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        PSC_ADDR_STATUS: rdata_next = status_now;
        PSC_ADDR_CONTROL: rdata_next = {6'h00, shutdown_en_reg, measure_go_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      shutdown_en_reg <= PSC_CONTROL_RESET[PSC_BIT_SHUTDOWN_EN];
      measure_go_reg <= PSC_CONTROL_RESET[PSC_BIT_MEASURE_GO];
      shutdown_req_reg <= 1'b0;
      cell_level_reg <= PSC_CELL_BELOW_LOW;
      rdata_reg <= 8'h00;
    end else begin
      shutdown_en_reg <= shutdown_en_next;
      measure_go_reg <= measure_go_next;
      shutdown_req_reg <= shutdown_req_next;
      cell_level_reg <= cell_level_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign backup_cell_measure_start = measure_go_reg;
  assign powerfail_shutdown_req = shutdown_req_reg;
  assign powerfail_shutdown_en = shutdown_en_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_go_write;
    reg_wr && reg_addr == PSC_ADDR_CONTROL && reg_wdata[PSC_BIT_MEASURE_GO];
  endsequence
  property p_go_pulse;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      s_go_write |=> measure_go_reg ##1
        (!measure_go_reg ||
         $past(reg_wr && reg_addr == PSC_ADDR_CONTROL && reg_wdata[PSC_BIT_MEASURE_GO]));
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("go bit not one-shot");
  property p_go_zero;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !(reg_wr && reg_addr == PSC_ADDR_CONTROL && reg_wdata[0]) |=> !measure_go_reg;
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("go bit set without write");
  property p_shut;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      shutdown_en_reg && !powerfail_out_n |=> powerfail_shutdown_req;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown missed");
  property p_noshut;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !shutdown_en_reg |=> !powerfail_shutdown_req;
  endproperty
  a_noshut: assert property (p_noshut) else $error("shutdown while disabled");
  property p_rd_status;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_STATUS |=> reg_rdata[3:2] == $past(power_state_in);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status readback wrong");
  property p_rd_ac;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_STATUS |=> reg_rdata[5] == !$past(adapter_detect_pin);
  endproperty
  a_rd_ac: assert property (p_rd_ac) else $error("adapter bit polarity");
  property p_rd_pb;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_STATUS |=> reg_rdata[4] == !$past(pushbutton_pin);
  endproperty
  a_rd_pb: assert property (p_rd_pb) else $error("button bit polarity");
  property p_rd_ctl;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_CONTROL |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("reserved bits nonzero");
  property p_seal;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_STATUS |=> reg_rdata[7:6] == $past({seal_broken_in,
                                                                  nvm_changed_in});
  endproperty
  a_seal: assert property (p_seal) else $error("seal or nvm bit wrong");
  property p_lvl;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      cell_level_valid |=> cell_level_reg == $past(cell_level_in);
  endproperty
  a_lvl: assert property (p_lvl) else $error("cell level not captured");

  // ----------------------------------------------------------------
  // checks: decode and hold
  // ----------------------------------------------------------------
  // expectations use inputs and stored bits, not the status function, so a slip there shows
  sequence s_ctl_write;
    reg_wr && reg_addr == PSC_ADDR_CONTROL;
  endsequence
  sequence s_status_read;
    reg_rd && reg_addr == PSC_ADDR_STATUS;
  endsequence
  property p_en_write;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      s_ctl_write |=> shutdown_en_reg == $past(reg_wdata[PSC_BIT_SHUTDOWN_EN]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("shutdown enable not stored");
  property p_en_hold;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !(reg_wr && reg_addr == PSC_ADDR_CONTROL) |=> $stable(shutdown_en_reg);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable moved without write");
  property p_rd_lvl;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      s_status_read |=> reg_rdata[1:0] == $past(cell_level_reg);
  endproperty
  a_rd_lvl: assert property (p_rd_lvl) else $error("cell level readback wrong");
  property p_lvl_hold;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !cell_level_valid |=> $stable(cell_level_reg);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("cell level moved");
  property p_rd_unmapped;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr != PSC_ADDR_STATUS && reg_addr != PSC_ADDR_CONTROL |=>
        reg_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
  property p_rd_hold;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rd_ctl_bits;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      reg_rd && reg_addr == PSC_ADDR_CONTROL |=>
        reg_rdata[1:0] == $past({shutdown_en_reg, measure_go_reg});
  endproperty
  a_rd_ctl_bits: assert property (p_rd_ctl_bits) else $error("control readback wrong");
  property p_nofail;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      powerfail_out_n |=> !powerfail_shutdown_req;
  endproperty
  a_nofail: assert property (p_nofail) else $error("shutdown without trip");
  property p_req_quiet;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      !shutdown_en_reg || powerfail_out_n |=> !powerfail_shutdown_req;
  endproperty
  a_req_quiet: assert property (p_req_quiet) else $error("shutdown request spurious");
endmodule : psc_regs

/* tb/psc_host.sv */
// psc_host: host side model issuing single-byte register reads and writes
// assumes the register block takes strobes on rising sys_clk; drives at falling edge
`timescale 1ns/100ps
module psc_host (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse, so a stale value is never mistaken for live data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : psc_host

/* tb/tb_top.sv */
// tb_top: self-checking bench for psc_regs driven through the host model
// assumes 50 MHz sys_clk and the strobe contract of the register block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin comparisons++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  import psc_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, ac = 1'b1, btn = 1'b1, pfo = 1'b1, seal = 1'b0;
  logic nvm = 1'b0, vld = 1'b0, wr, rd, start, req, en;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] lvl = 2'h0;
  psc_state_t st = PSC_ST_TRANSITIONAL;
  int mismatches = 0;
  int comparisons = 0;
  psc_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .adapter_detect_pin(ac),
    .pushbutton_pin(btn), .powerfail_out_n(pfo), .seal_broken_in(seal),
    .nvm_changed_in(nvm), .power_state_in(st), .cell_level_in(lvl),
    .cell_level_valid(vld), .backup_cell_measure_start(start),
    .powerfail_shutdown_req(req), .powerfail_shutdown_en(en));
  psc_host host_u (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // the run needs well under 300 cycles; this ceiling only catches a hang
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    host_u.rd(8'h06, d);
    `CHK("control reset", 8'h00, d)
    host_u.rd(8'h05, d);
    `CHK("status reset", 8'h00, d)
    for (int i = 0; i < 4; i++) begin
      seal = i[0];
      nvm = i[1];
      ac = i[1];
      btn = i[0];
      st = psc_state_t'(i[1:0]);
      lvl = i[1:0];
      host_u.wr(8'h06, 8'h01);
      `CHK("measure start", 1'b1, start)
      vld = 1'b1;
      @(negedge sys_clk);
      vld = 1'b0;
      `CHK("start cleared", 1'b0, start)
      host_u.wr(8'h05, 8'hFF);
      host_u.rd(8'h05, d);
      `CHK("status", {i[0], i[1], ~i[1], ~i[0], i[1:0], i[1:0]}, d)
    end
    host_u.wr(8'h06, 8'hFE);
    `CHK("no start", 1'b0, start)
    host_u.rd(8'h06, d);
    `CHK("control", 8'h02, d)
    `CHK("shutdown en", 1'b1, en)
    pfo = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("shutdown on trip", 1'b1, req)
    pfo = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("no trip", 1'b0, req)
    host_u.wr(8'h06, 8'h00);
    pfo = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("trip disabled", 1'b0, req)
    host_u.wr(8'h06, 8'h02);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("req in reset", 1'b0, req)
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("en after reset", 1'b0, en)
    host_u.rd(8'h06, d);
    `CHK("control after reset", 8'h00, d)
    host_u.rd(8'h2A, d);
    `CHK("unmapped", 8'h00, d)
    close_out();
  end
endmodule : tb_top
